//--- rtl/dds_freq_regs.vh
`ifndef DDS_FREQ_REGS_VH
`define DDS_FREQ_REGS_VH

// ------------------------------------------------------------
// register word addresses
// ------------------------------------------------------------
`define ADDR_CTRL         5'h00
`define ADDR_DISPLAY      5'h01
`define ADDR_RX_IF        5'h02
`define ADDR_TX_IF        5'h03
`define ADDR_RX_MARK      5'h04
`define ADDR_TX_MARK      5'h05
`define ADDR_SPACE_SHIFT  5'h06
`define ADDR_BAND_SEL     5'h07
`define ADDR_BAND_CFG     5'h08
`define ADDR_STATUS       5'h09
`define ADDR_RX_OUT       5'h0A
`define ADDR_TX_MARK_OUT  5'h0B
`define ADDR_TX_SPACE_OUT 5'h0C
`define ADDR_DDS_OUT      5'h0D

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTRL_FSK_BIT      0
`define CTRL_INIT_BIT     1
`define CFG_RX_MODE_LSB   0
`define CFG_TX_MODE_LSB   2
`define CFG_RX_SCALE_LSB  8
`define CFG_TX_SCALE_LSB  16
`define STAT_BAND_LSB     0
`define STAT_KEY_BIT      4
`define STAT_TXD_BIT      5
`define STAT_BUSY_BIT     6
`define STAT_TX_BIT       7

// ------------------------------------------------------------
// offset modes
// ------------------------------------------------------------
`define MODE_DIRECT       2'h0
`define MODE_VFO_PLUS_IF  2'h1
`define MODE_VFO_MINUS_IF 2'h2
`define MODE_IF_MINUS_VFO 2'h3

// ------------------------------------------------------------
// bands and factory values
// ------------------------------------------------------------
`define BAND_COUNT        13
`define BAND_LAST         4'hC
`define BAND_SIX_M        4'hA
`define BAND_TWO_M        4'hB
`define OFFSET_MAX        32'h10000000
`define DEF_TX_MARK       32'h0000084D
`define DEF_SPACE_SHIFT   32'h000000AA
`define DEF_SCALE         8'h01
`define DEF_SCALE_SIX_M   8'h02
`define DEF_SCALE_TWO_M   8'h05
`define DEF_ZERO          32'h00000000

`endif

//--- rtl/freq_divider.v
`timescale 1ns/1ps

// ------------------------------------------------------------
// restoring divider, one quotient bit per clock
// ------------------------------------------------------------
module freq_divider #(
    parameter DW = 32,
    parameter SW = 8,
    parameter CW = 6
) (
    // clock and reset
    input  wire          mclk,
    input  wire          reset_n,
    // request
    input  wire          start,
    input  wire [DW-1:0] dividend,
    input  wire [SW-1:0] divisor,
    // answer
    output reg           busy,
    output reg           done,
    output reg  [DW-1:0] quotient
);

    reg  [SW-1:0] rem;
    reg  [DW-1:0] quo;
    reg  [SW-1:0] div_q;
    reg  [CW-1:0] count;
    wire [SW:0]   rem_sh;
    wire          fits;
    wire [SW:0]   rem_sub;

    // shifted partial remainder and trial subtraction
    assign rem_sh  = {rem, quo[DW-1]};
    assign fits    = (rem_sh >= {1'b0, div_q});
    assign rem_sub = rem_sh - {1'b0, div_q};

    // iteration; zero divisor treated as one
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rem      <= {SW{1'b0}};
            quo      <= {DW{1'b0}};
            div_q    <= {SW{1'b0}};
            count    <= {CW{1'b0}};
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= {DW{1'b0}};
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem   <= {SW{1'b0}};
                quo   <= dividend;
                div_q <= (divisor == {SW{1'b0}}) ?
                         {{(SW-1){1'b0}}, 1'b1} : divisor;
                count <= DW[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
                busy  <= 1'b1;
            end else if (busy) begin
                if (fits) begin
                    rem <= rem_sub[SW-1:0];
                    quo <= {quo[DW-2:0], 1'b1};
                end else begin
                    rem <= rem_sh[SW-1:0];
                    quo <= {quo[DW-2:0], 1'b0};
                end
                if (count == {CW{1'b0}}) begin
                    busy     <= 1'b0;
                    done     <= 1'b1;
                    quotient <= {quo[DW-2:0], fits}; // truncated result
                end else begin
                    count <= count - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

//--- rtl/dds_frequency_calc.v
`timescale 1ns/1ps
`include "dds_freq_regs.vh"

// Behaviour
// RL1: receive mid value: display+IF, display-IF, IF-display or display.
// RL2: normal mode divides receive intermediate by band receive scale.
// RL3: transmit mid value: display+IF, display-IF, IF-display or display.
// RL4: normal mode divides transmit intermediate by band transmit scale.
// RL5: each of thirteen bands holds its own modes and scales.
// RL6: frequency-shift mode subtracts receive mark offset before dividing.
// RL7: transmit mark output is intermediate minus mark offset, then divided.
// RL8: transmit space output also subtracts the space shift, then divided.
// RL9: mark is default; space chosen when serial transmit data is high.
// RL10: factory defaults load transmit mark offset with 2125 Hz.
// RL11: factory defaults load space shift offset with 170 Hz.
// RL12: receive mark offset accepted up to the IF offset maximum.
// RL13: transmit mark and space shift accepted up to that maximum.
// RL14: factory defaults give six-metre transmit scale of two.
// RL15: factory defaults give two-metre transmit scale of five.
// RL16: key low delivers transmit result; key high delivers receive result.
// RL17: IF offsets saturate at the maximum instead of exceeding it.
// RL18: unsigned hertz, truncated division, recompute on every input change.
module dds_frequency_calc #(
    parameter FW = 32,
    parameter SW = 8
) (
    // clock and reset
    input  wire          mclk,
    input  wire          reset_n,
    // register port
    input  wire [4:0]    addr,
    input  wire [31:0]   wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [31:0]   rdata,
    // pins from the radio
    input  wire [3:0]    band,
    input  wire          key_n,
    input  wire          serial_txd,
    // synthesizer frequency
    output reg  [FW-1:0] dds_freq,
    output wire          calc_busy
);

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_LOAD = 2'h2;

    reg  [1:0]    state;
    reg           fsk_mode;
    reg  [FW-1:0] display;
    reg  [FW-1:0] rx_if;
    reg  [FW-1:0] tx_if;
    reg  [FW-1:0] rx_mark_off;
    reg  [FW-1:0] tx_mark_off;
    reg  [FW-1:0] space_shift_offset;
    reg  [3:0]    band_sel;
    reg  [1:0]    rx_mode  [0:`BAND_COUNT-1];
    reg  [1:0]    tx_mode  [0:`BAND_COUNT-1];
    reg  [SW-1:0] rx_scale [0:`BAND_COUNT-1];
    reg  [SW-1:0] tx_scale [0:`BAND_COUNT-1];
    reg  [FW-1:0] rx_freq;
    reg  [FW-1:0] tx_mark_freq;
    reg  [FW-1:0] tx_space_freq;
    reg           dirty;
    reg  [3:0]    band_s1;
    reg  [3:0]    band_s2;
    reg           key_s1;
    reg           key_s2;
    reg           txd_s1;
    reg           txd_s2;
    reg  [3:0]    band_last;
    wire [3:0]    band_idx;
    wire [3:0]    sel_idx;
    wire          band_moved;
    wire          init_req;
    wire          calc_start;
    wire [FW-1:0] rx_mid;
    wire [FW-1:0] tx_mid;
    wire [FW-1:0] rx_div_in;
    wire [FW-1:0] mark_div_in;
    wire [FW-1:0] space_div_in;
    wire [FW-1:0] rx_q;
    wire [FW-1:0] mark_q;
    wire [FW-1:0] space_q;
    wire          rx_done;
    wire          mark_done;
    wire          space_done;
    wire [FW-1:0] next_dds_freq;
    integer       i;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // clamp an offset to the largest accepted value
    function [FW-1:0] sat_off;
        input [31:0] v;
        begin
            if (v > `OFFSET_MAX)
                sat_off = `OFFSET_MAX; // [RL17] [RL12] [RL13]
            else
                sat_off = v[FW-1:0];
        end
    endfunction
    // difference floored at zero
    function [FW-1:0] sub_floor;
        input [FW-1:0] a;
        input [FW-1:0] b;
        begin
            sub_floor = (a > b) ? (a - b) : {FW{1'b0}};
        end
    endfunction
    // offset mode applied to display and IF
    function [FW-1:0] apply_mode;
        input [1:0]    mode;
        input [FW-1:0] disp;
        input [FW-1:0] ifv;
        reg   [FW:0]   sum;
        begin
            sum = {1'b0, disp} + {1'b0, ifv};
            case (mode)
                `MODE_VFO_PLUS_IF:
                    apply_mode = sum[FW] ? {FW{1'b1}} : sum[FW-1:0];
                `MODE_VFO_MINUS_IF: apply_mode = sub_floor(disp, ifv);
                `MODE_IF_MINUS_VFO: apply_mode = sub_floor(ifv, disp);
                default:            apply_mode = disp;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two flops on each pin before use
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            band_s1 <= 4'h0;
            band_s2 <= 4'h0;
            key_s1  <= 1'b1;
            key_s2  <= 1'b1;
            txd_s1  <= 1'b0;
            txd_s2  <= 1'b0;
        end else begin
            band_s1 <= band;
            band_s2 <= band_s1;
            key_s1  <= key_n;
            key_s2  <= key_s1;
            txd_s1  <= serial_txd;
            txd_s2  <= txd_s1;
        end
    end

    // out-of-range band codes use the last table entry
    assign band_idx = (band_s2 > `BAND_LAST) ? `BAND_LAST : band_s2; // [RL5]
    assign sel_idx  = (band_sel > `BAND_LAST) ? `BAND_LAST : band_sel;
    assign band_moved = (band_idx != band_last);
    assign init_req   = wr && (addr == `ADDR_CTRL) && wdata[`CTRL_INIT_BIT];

    // ------------------------------------------------------------
    // register writes and factory defaults
    // ------------------------------------------------------------
    // reset and the init bit both load factory values
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fsk_mode           <= 1'b0;
            display            <= `DEF_ZERO;
            rx_if              <= `DEF_ZERO;
            tx_if              <= `DEF_ZERO;
            rx_mark_off        <= `DEF_ZERO;
            tx_mark_off        <= `DEF_TX_MARK;     // [RL10]
            space_shift_offset <= `DEF_SPACE_SHIFT; // [RL11]
            band_sel           <= 4'h0;
            for (i = 0; i < `BAND_COUNT; i = i + 1) begin
                rx_mode[i]  <= `MODE_DIRECT;
                tx_mode[i]  <= `MODE_DIRECT;
                rx_scale[i] <= `DEF_SCALE;
                tx_scale[i] <= `DEF_SCALE;
            end
            tx_scale[`BAND_SIX_M] <= `DEF_SCALE_SIX_M; // [RL14]
            tx_scale[`BAND_TWO_M] <= `DEF_SCALE_TWO_M; // [RL15]
        end else if (init_req) begin
            fsk_mode           <= wdata[`CTRL_FSK_BIT];
            rx_if              <= `DEF_ZERO;
            tx_if              <= `DEF_ZERO;
            rx_mark_off        <= `DEF_ZERO;
            tx_mark_off        <= `DEF_TX_MARK;     // [RL10]
            space_shift_offset <= `DEF_SPACE_SHIFT; // [RL11]
            for (i = 0; i < `BAND_COUNT; i = i + 1) begin
                rx_mode[i]  <= `MODE_DIRECT;
                tx_mode[i]  <= `MODE_DIRECT;
                rx_scale[i] <= `DEF_SCALE;
                tx_scale[i] <= `DEF_SCALE;
            end
            tx_scale[`BAND_SIX_M] <= `DEF_SCALE_SIX_M; // [RL14]
            tx_scale[`BAND_TWO_M] <= `DEF_SCALE_TWO_M; // [RL15]
        end else if (wr) begin
            case (addr)
                `ADDR_CTRL:         fsk_mode <= wdata[`CTRL_FSK_BIT];
                `ADDR_DISPLAY:      display <= wdata[FW-1:0];
                `ADDR_RX_IF:        rx_if <= sat_off(wdata);       // [RL17]
                `ADDR_TX_IF:        tx_if <= sat_off(wdata);       // [RL17]
                `ADDR_RX_MARK:      rx_mark_off <= sat_off(wdata); // [RL12]
                `ADDR_TX_MARK:      tx_mark_off <= sat_off(wdata); // [RL13]
                `ADDR_SPACE_SHIFT:  space_shift_offset <= sat_off(wdata);
                `ADDR_BAND_SEL:     band_sel <= wdata[3:0];
                `ADDR_BAND_CFG: begin
                    rx_mode[sel_idx]  <= wdata[`CFG_RX_MODE_LSB +: 2];
                    tx_mode[sel_idx]  <= wdata[`CFG_TX_MODE_LSB +: 2];
                    rx_scale[sel_idx] <= wdata[`CFG_RX_SCALE_LSB +: SW];
                    tx_scale[sel_idx] <= wdata[`CFG_TX_SCALE_LSB +: SW];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // dividends
    // ------------------------------------------------------------
    assign rx_mid = apply_mode(rx_mode[band_idx], display, rx_if); // [RL1]
    assign tx_mid = apply_mode(tx_mode[band_idx], display, tx_if); // [RL3]
    // mark and space offsets only apply in shift keying mode
    assign rx_div_in    = fsk_mode ? sub_floor(rx_mid, rx_mark_off)
                                   : rx_mid;                 // [RL6] [RL2]
    assign mark_div_in  = fsk_mode ? sub_floor(tx_mid, tx_mark_off)
                                   : tx_mid;                 // [RL7] [RL4]
    assign space_div_in = fsk_mode ? sub_floor(mark_div_in,
                                               space_shift_offset)
                                   : tx_mid;                 // [RL8]

    // ------------------------------------------------------------
    // recompute sequencer
    // ------------------------------------------------------------
    assign calc_start = (state == ST_IDLE) && dirty;
    assign calc_busy  = (state != ST_IDLE);
    // a change arriving as a run starts keeps the flag set
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dirty     <= 1'b1;
            band_last <= 4'h0;
            state     <= ST_IDLE;
        end else begin
            band_last <= band_idx;
            if (wr || band_moved)
                dirty <= 1'b1;                               // [RL18]
            else if (calc_start)
                dirty <= 1'b0;
            case (state)
                ST_IDLE: if (dirty) state <= ST_RUN;
                ST_RUN:  if (rx_done) state <= ST_LOAD;
                ST_LOAD: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // three dividers run in lockstep
    freq_divider #(.DW(FW), .SW(SW), .CW(6)) u_div_rx (
        .mclk(mclk), .reset_n(reset_n), .start(calc_start), .busy(),
        .dividend(rx_div_in), .divisor(rx_scale[band_idx]),    // [RL2]
        .done(rx_done), .quotient(rx_q));
    freq_divider #(.DW(FW), .SW(SW), .CW(6)) u_div_mark (
        .mclk(mclk), .reset_n(reset_n), .start(calc_start), .busy(),
        .dividend(mark_div_in), .divisor(tx_scale[band_idx]),  // [RL4]
        .done(mark_done), .quotient(mark_q));
    freq_divider #(.DW(FW), .SW(SW), .CW(6)) u_div_space (
        .mclk(mclk), .reset_n(reset_n), .start(calc_start), .busy(),
        .dividend(space_div_in), .divisor(tx_scale[band_idx]), // [RL8]
        .done(space_done), .quotient(space_q));

    // ------------------------------------------------------------
    // results and output selection
    // ------------------------------------------------------------
    // key low transmits; txd high picks space in shift mode
    assign next_dds_freq = key_s2 ? rx_freq :                // [RL16]
                           (fsk_mode && txd_s2) ? tx_space_freq
                                                : tx_mark_freq; // [RL9]
    // receive, mark and space results latched together once all three dividers finish
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_freq       <= {FW{1'b0}};
            tx_mark_freq  <= {FW{1'b0}};
            tx_space_freq <= {FW{1'b0}};
            dds_freq      <= {FW{1'b0}};
        end else begin
            if (rx_done && mark_done && space_done) begin
                rx_freq       <= rx_q;
                tx_mark_freq  <= mark_q;
                tx_space_freq <= space_q;
            end
            dds_freq <= next_dds_freq;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // read data valid in the cycle after the strobe
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= 32'h00000000;
            case (addr)
                `ADDR_CTRL:         rdata[`CTRL_FSK_BIT] <= fsk_mode;
                `ADDR_DISPLAY:      rdata[FW-1:0] <= display;
                `ADDR_RX_IF:        rdata[FW-1:0] <= rx_if;
                `ADDR_TX_IF:        rdata[FW-1:0] <= tx_if;
                `ADDR_RX_MARK:      rdata[FW-1:0] <= rx_mark_off;
                `ADDR_TX_MARK:      rdata[FW-1:0] <= tx_mark_off;
                `ADDR_SPACE_SHIFT:  rdata[FW-1:0] <= space_shift_offset;
                `ADDR_BAND_SEL:     rdata[3:0] <= band_sel;
                `ADDR_BAND_CFG: begin
                    rdata[`CFG_RX_MODE_LSB +: 2]   <= rx_mode[sel_idx];
                    rdata[`CFG_TX_MODE_LSB +: 2]   <= tx_mode[sel_idx];
                    rdata[`CFG_RX_SCALE_LSB +: SW] <= rx_scale[sel_idx];
                    rdata[`CFG_TX_SCALE_LSB +: SW] <= tx_scale[sel_idx];
                end
                `ADDR_STATUS: begin
                    rdata[`STAT_BAND_LSB +: 4] <= band_idx;
                    rdata[`STAT_KEY_BIT]       <= key_s2;
                    rdata[`STAT_TXD_BIT]       <= txd_s2;
                    rdata[`STAT_BUSY_BIT]      <= calc_busy;
                    rdata[`STAT_TX_BIT]        <= ~key_s2;
                end
                `ADDR_RX_OUT:       rdata[FW-1:0] <= rx_freq;
                `ADDR_TX_MARK_OUT:  rdata[FW-1:0] <= tx_mark_freq;
                `ADDR_TX_SPACE_OUT: rdata[FW-1:0] <= tx_space_freq;
                `ADDR_DDS_OUT:      rdata[FW-1:0] <= dds_freq;
                default: ;
            endcase
        end
    end

endmodule

//--- verification/dds_frequency_calc_properties.sv
`timescale 1ns/1ps
`include "dds_freq_regs.vh"

// ------------------------------------------------------------
// port checker for the frequency calculator
// ------------------------------------------------------------
module dds_calc_checker #(
    parameter FW = 32,
    parameter SW = 8
) (
    // clock and reset
    input wire          mclk,
    input wire          reset_n,
    // register port
    input wire [4:0]    addr,
    input wire [31:0]   wdata,
    input wire          wr,
    input wire          rd,
    input wire [31:0]   rdata,
    // radio pins
    input wire [3:0]    band,
    input wire          key_n,
    input wire          serial_txd,
    // synthesizer side
    input wire [FW-1:0] dds_freq,
    input wire          calc_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // idle with steady pins long enough for the sync stages to settle
    sequence pins_quiet;
        (!calc_busy && $stable(key_n) && $stable(serial_txd)
            && $stable(band))[*6];
    endsequence
    // a run lasts well beyond a few cycles
    sequence run_held;
        calc_busy[*8];
    endsequence

    a_wr_starts_run: assert property (wr |-> ##[1:3] calc_busy)
        else $error("no recompute after a write");
    a_reset_run: assert property (
        $rose(reset_n) |-> ##[0:2] calc_busy)
        else $error("no recompute after reset");
    a_run_minimum: assert property ($rose(calc_busy) |-> run_held)
        else $error("run ended too soon");
    a_run_bounded: assert property (
        calc_busy |-> ##[0:120] !calc_busy)
        else $error("run never ends");
    a_dds_settled: assert property (pins_quiet |-> $stable(dds_freq))
        else $error("output moved with nothing changed");
    a_dds_readback: assert property (
        rd && addr == `ADDR_DDS_OUT |=> rdata == $past(dds_freq))
        else $error("output readback differs");
    a_unmapped_zero: assert property (
        rd && addr > `ADDR_DDS_OUT |=> rdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
endmodule

bind dds_frequency_calc dds_calc_checker #(.FW(FW), .SW(SW)) chk (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .band(band), .key_n(key_n),
    .serial_txd(serial_txd), .dds_freq(dds_freq),
    .calc_busy(calc_busy));

//--- verification/dds_synth_model.sv
`timescale 1ns/1ps

// synthesizer: latches the requested frequency each clock
module dds_synth_model #(
    parameter FW = 32
) (
    // clock and reset
    input  wire          mclk,
    input  wire          reset_n,
    // frequency request
    input  wire [FW-1:0] freq,
    output logic [FW-1:0] tuned
);
    // tuning follows the request one clock later
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            tuned <= '0;
        else
            tuned <= freq;
    end
endmodule

//--- verification/dds_frequency_calc_bench.sv
`timescale 1ns/1ps
`include "dds_freq_regs.vh"

module dds_frequency_calc_bench;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h00000000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  band = 4'h0;
    logic        key_n = 1'b1;
    logic        serial_txd = 1'b0;
    wire  [31:0] rdata;
    wire  [31:0] dds_freq;
    wire  [31:0] tuned;
    wire         calc_busy;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          m;
    logic [31:0] d;
    logic [31:0] rx_if;
    logic [31:0] tx_if;

    always #50 mclk = ~mclk;

    dds_frequency_calc uut (.mclk(mclk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .band(band),
        .key_n(key_n), .serial_txd(serial_txd), .dds_freq(dds_freq),
        .calc_busy(calc_busy));
    dds_synth_model synth (.mclk(mclk), .reset_n(reset_n),
        .freq(dds_freq), .tuned(tuned));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // read data stand from the cycle after the strobe until the next read
    task automatic rd_reg(input logic [4:0] a, input logic [31:0] exp,
                          input string what);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, what);
    endtask

    // bounded wait for two idle samples; one idle cycle sits between runs
    task automatic wait_idle;
        int i;
        int quiet;
        quiet = 0;
        repeat (5) @(posedge mclk);
        for (i = 0; i < 200 && quiet < 2; i++) begin
            @(posedge mclk);
            #1;
            quiet = (calc_busy === 1'b0) ? quiet + 1 : 0;
        end
        if (quiet < 2) begin
            n_mismatch++;
            $display("wrong value at %0t: run never ends", $time);
            end_of_test;
        end
        repeat (2) @(posedge mclk);
    endtask

    // offset mode arithmetic, clamped at zero below
    function automatic logic [31:0] vfo(input int md, input logic [31:0] dv,
                                        input logic [31:0] iv);
        case (md)
            1: return dv + iv;
            2: return (dv > iv) ? dv - iv : 32'h00000000;
            3: return (iv > dv) ? iv - dv : 32'h00000000;
            default: return dv;
        endcase
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        check(dds_freq, 32'h00000000, "reset output");
        reset_n <= 1'b1;
        wait_idle;
        rd_reg(`ADDR_TX_MARK, 32'h0000084D, "mark default");
        rd_reg(`ADDR_SPACE_SHIFT, 32'h000000AA, "shift default");
        wr_reg(`ADDR_BAND_SEL, 32'h0000000A);
        rd_reg(`ADDR_BAND_CFG, 32'h00020100, "six m cfg");
        wr_reg(`ADDR_BAND_SEL, 32'h0000000B);
        rd_reg(`ADDR_BAND_CFG, 32'h00050100, "two m cfg");
        rd_reg(5'h1F, 32'h00000000, "unmapped");
        $display("test defaults done");
        // every offset mode with odd scales on band 0
        d = 32'h000F4240;
        rx_if = 32'h000493E0;
        tx_if = 32'h002625A0;
        wr_reg(`ADDR_DISPLAY, d);
        wr_reg(`ADDR_RX_IF, rx_if);
        wr_reg(`ADDR_TX_IF, tx_if);
        wr_reg(`ADDR_BAND_SEL, 32'h00000000);
        for (m = 0; m < 4; m++) begin
            wr_reg(`ADDR_BAND_CFG, {16'h0703, 4'h0, m[1:0], m[1:0]});
            wait_idle;
            rd_reg(`ADDR_RX_OUT, vfo(m, d, rx_if) / 32'h3,
                   "rx");
            rd_reg(`ADDR_TX_MARK_OUT, vfo(m, d, tx_if) / 32'h7,
                   "tx");
        end
        $display("test modes done");
        // band pin picks its own table entry
        wr_reg(`ADDR_BAND_SEL, 32'h00000001);
        wr_reg(`ADDR_BAND_CFG, 32'h00010100);
        @(posedge mclk);
        band <= 4'h1;
        wait_idle;
        rd_reg(`ADDR_RX_OUT, d, "band one");
        $display("test bands done");
        // keying offsets, then pins choose the output
        wr_reg(`ADDR_CTRL, 32'h00000001);
        wr_reg(`ADDR_RX_MARK, 32'h0000052D);
        wait_idle;
        rd_reg(`ADDR_RX_OUT, d - 32'h0000052D, "fsk rx");
        rd_reg(`ADDR_TX_MARK_OUT, d - 32'h0000084D, "fsk mark");
        rd_reg(`ADDR_TX_SPACE_OUT, d - 32'h000008F7, "fsk space");
        for (m = 0; m < 3; m++) begin
            @(posedge mclk);
            key_n <= (m == 2);
            serial_txd <= (m != 0);
            repeat (5) @(posedge mclk);
            #1;
            check(tuned, d - (m == 0 ? 32'h0000084D : m == 1 ? 32'h000008F7
                  : 32'h0000052D), "synth");
        end
        rd_reg(`ADDR_DDS_OUT, d - 32'h0000052D, "dds out");
        rd_reg(`ADDR_STATUS, 32'h00000031, "status");
        $display("test keying done");
        // offsets peg at the maximum
        wr_reg(`ADDR_RX_IF, 32'hFFFFFFFF);
        rd_reg(`ADDR_RX_IF, 32'h10000000, "if peg");
        wr_reg(`ADDR_TX_MARK, 32'h20000000);
        rd_reg(`ADDR_TX_MARK, 32'h10000000, "mark peg");
        wr_reg(`ADDR_SPACE_SHIFT, 32'h0FFFFFFF);
        rd_reg(`ADDR_SPACE_SHIFT, 32'h0FFFFFFF, "shift big");
        wr_reg(`ADDR_RX_MARK, 32'h10000000);
        rd_reg(`ADDR_RX_MARK, 32'h10000000, "rx mark max");
        // init bit reloads factory offsets
        wr_reg(`ADDR_CTRL, 32'h00000002);
        rd_reg(`ADDR_TX_MARK, 32'h0000084D, "init mark");
        rd_reg(`ADDR_SPACE_SHIFT, 32'h000000AA, "init shift");
        rd_reg(`ADDR_RX_IF, 32'h00000000, "init if");
        wait_idle;
        $display("test limits done");
        end_of_test;
    end
endmodule
